// ===== logic/acs_sequencer.sv
// Function
// R1 - Writing start bit begins conversion; bit reads one until it completes
// R2 - Channel change mid-conversion takes effect only after it finishes
// R3 - Result-ready flag sets on completion regardless of interrupt enable
// R4 - Interrupt request only while flag and its enable are both set
// R5 - Events start conversions only while start-event enable is one
// R6 - Event rising edge sets start bit, cleared on completion
// R7 - Free-running mode restarts right after each completion
// R8 - Accumulator cleared at start of every accumulated conversion
// R9 - Accumulation uses 12-bit samples, truncated or not by configuration
// R10 - Accumulation count sums up to 128 samples per trigger
// R11 - Prescaler derives converter clock using divider select
// R12 - Prescaler starts at conversion start, reset for each conversion
// R13 - Prescaler held in reset while idle
// R14 - Conversion begins one cycle after trigger, never beyond two
// R15 - Result is 10 or 12 bits by resolution select
// R16 - Single-ended or differential conversion by differential select
// R17 - Software leaves conversion settings alone during a conversion
// R18 - Software configures everything, then sets converter enable last
// R19 - Two converter cycles sample-and-hold, then 13.5 conversion
// R20 - Two peripheral cycles of formatting before result and flag
// R21 - Result register updated no later than result-ready flag
// R22 - Trigger during a running conversion does not disturb it
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module acs_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_in,
  input  wire logic [11:0] core_data,
  output logic             adc_clk,
  output logic             sample_hold,
  output logic             converting,
  output logic [4:0]       positive_input_select,
  output logic [4:0]       negative_input_select,
  output logic             differential_select,
  output logic             resolution_select,
  output logic             irq
);

  acs_pkg::acs_regs_t st_q;
  acs_pkg::acs_regs_t st_d;
  logic               half_tick;
  logic               wr;
  logic               start_wr;
  logic               ev_rise;
  logic               trig;
  logic               done;
  logic signed [19:0] acc_new;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic known(input logic [7:0] a);
    known = a == acs_pkg::OFS_CTRL_A || a == acs_pkg::OFS_CTRL_B ||
            a == acs_pkg::OFS_CTRL_C || a == acs_pkg::OFS_POS_SEL ||
            a == acs_pkg::OFS_NEG_SEL || a == acs_pkg::OFS_COMMAND ||
            a == acs_pkg::OFS_EV_CTRL || a == acs_pkg::OFS_INT_CTRL ||
            a == acs_pkg::OFS_INT_FLAG || a == acs_pkg::OFS_RESULT;
  endfunction : known

  // Turn the accumulated sum into the 16-bit result word
  function automatic logic [15:0] fmt(input acs_pkg::acs_regs_t s,
                                      input logic signed [19:0] a);
    logic signed [19:0] v;
    logic [2:0]         sh;
    v  = a;
    sh = 3'h0;
    if (s.samp_sel == 3'h0) begin
      if (s.res10) begin
        v = a >>> 2; // R15
      end
      if (s.ljust) begin
        v = s.res10 ? (v <<< 6) : (v <<< 4);
      end
    end else begin
      if (s.trunc && s.samp_sel > acs_pkg::TRUNC_FROM) begin
        sh = 3'(s.samp_sel - acs_pkg::TRUNC_FROM); // R9
      end
      v = a >>> sh;
    end
    fmt = v[15:0];
  endfunction : fmt

  acs_prescaler u_clock_divider_select (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (st_q.clock_divider_select_run),
    .div_sel   (st_q.div_sel),
    .half_tick (half_tick)
  );

  // ****************************************************************
  // Triggers
  // ****************************************************************
  // Unmapped writes are refused so they cannot start anything
  assign wr       = psel && penable && st_q.pready && pwrite &&
                    !st_q.pslverr;
  assign start_wr = wr && paddr == acs_pkg::OFS_COMMAND &&
                    pwdata[acs_pkg::B_START];                // R1
  assign ev_rise  = event_in && !st_q.ev_prev && st_q.ev_en; // R5 R6
  assign trig     = (start_wr || ev_rise) && st_q.enable &&
                    !st_q.busy;                              // R22
  assign done     = st_q.state == acs_pkg::ST_FORMAT &&
                    st_q.fcnt == acs_pkg::FMT_LAST && st_q.left == 8'h01;
  // Sample sign-extended in differential mode, 12 bits always
  assign acc_new  = st_q.acc + (st_q.diff ?
                    {{8{core_data[11]}}, core_data} :
                    {8'h00, core_data}); // R9 R16

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d         = st_q;
    st_d.ev_prev = event_in;
    // Register writes
    if (wr) begin
      case (paddr)
        acs_pkg::OFS_CTRL_A: begin
          st_d.enable   = pwdata[acs_pkg::B_ENABLE];
          st_d.free_run = pwdata[acs_pkg::B_FREE_RUN];
          st_d.res10    = pwdata[acs_pkg::B_RES10];
          st_d.ljust    = pwdata[acs_pkg::B_LJUST];
          st_d.diff     = pwdata[acs_pkg::B_DIFF];
        end
        acs_pkg::OFS_CTRL_B: begin
          st_d.samp_sel = pwdata[2:0]; // R10
          st_d.trunc    = pwdata[acs_pkg::B_TRUNC];
        end
        acs_pkg::OFS_CTRL_C:   st_d.div_sel = pwdata[2:0];
        acs_pkg::OFS_POS_SEL:  st_d.pos_req = pwdata[4:0];
        acs_pkg::OFS_NEG_SEL:  st_d.neg_req = pwdata[4:0];
        acs_pkg::OFS_EV_CTRL:  st_d.ev_en   = pwdata[acs_pkg::B_EV_EN];
        acs_pkg::OFS_INT_CTRL: st_d.rdy_ie  = pwdata[acs_pkg::B_RDY_IE];
        // Write one to clear; a completion below still wins
        acs_pkg::OFS_INT_FLAG: begin
          if (pwdata[acs_pkg::B_RDY_FLAG]) begin
            st_d.flag = 1'b0;
          end
        end
        default: st_d.flag = st_d.flag;
      endcase
    end
    // Sequencer
    case (st_q.state)
      acs_pkg::ST_IDLE: begin
        if (trig) begin
          st_d.busy = 1'b1; // R1 R6
        end
      end
      acs_pkg::ST_SAMPLE: begin
        if (half_tick) begin
          st_d.hcnt = 5'(st_q.hcnt + 5'h01);
          if (st_q.hcnt == 5'(acs_pkg::SH_HALVES - 5'h01)) begin // R19
            st_d.state = acs_pkg::ST_CONV;
            st_d.hcnt  = 5'h00;
          end
        end
      end
      acs_pkg::ST_CONV: begin
        if (half_tick) begin
          st_d.hcnt = 5'(st_q.hcnt + 5'h01);
          if (st_q.hcnt == 5'(acs_pkg::CONV_HALVES - 5'h01)) begin // R19
            st_d.state     = acs_pkg::ST_FORMAT;
            st_d.hcnt      = 5'h00;
            st_d.fcnt      = 1'b0;
            st_d.acc       = acc_new;
            st_d.clock_divider_select_run = 1'b0; // R12
          end
        end
      end
      acs_pkg::ST_FORMAT: begin
        st_d.fcnt = 1'b1; // R20
        if (st_q.fcnt == acs_pkg::FMT_LAST) begin
          if (st_q.left != 8'h01) begin
            st_d.left      = 8'(st_q.left - 8'h01);
            st_d.state     = acs_pkg::ST_SAMPLE;
            st_d.clock_divider_select_run = 1'b1;
          end else begin
            st_d.res   = fmt(st_q, st_q.acc); // R21
            st_d.flag  = 1'b1;                // R3
            st_d.state = acs_pkg::ST_IDLE;
            st_d.busy  = st_q.free_run; // R7
          end
        end
      end
      default: st_d.state = acs_pkg::ST_IDLE;
    endcase
    // Start of a burst: from a trigger, or a free-running restart
    if (trig || (done && st_q.free_run)) begin
      st_d.state     = acs_pkg::ST_SAMPLE; // R14
      st_d.acc       = '0;                 // R8
      st_d.left      = 8'(8'h01 << st_q.samp_sel); // R10
      st_d.hcnt      = 5'h00;
      st_d.clock_divider_select_run = 1'b1;      // R12
      st_d.pos_cur   = st_q.pos_req; // R2
      st_d.neg_cur   = st_q.neg_req;
    end
    // Converter clock follows half ticks, low while idle
    if (!st_d.clock_divider_select_run) begin
      st_d.adc_clk = 1'b0;
    end else if (half_tick && st_q.clock_divider_select_run) begin
      st_d.adc_clk = !st_q.adc_clk;
    end
    st_d.sh  = st_d.state == acs_pkg::ST_SAMPLE;
    st_d.cv  = st_d.state == acs_pkg::ST_CONV;
    st_d.irq = st_d.flag && st_d.rdy_ie; // R4
    // APB answer: ready in the first access cycle, data from setup
    st_d.pready  = psel && !penable;
    st_d.pslverr = psel && !penable && !known(paddr);
    st_d.prdata  = '0;
    if (psel && !penable) begin
      case (paddr)
        acs_pkg::OFS_CTRL_A: begin
          st_d.prdata[acs_pkg::B_ENABLE]   = st_q.enable;
          st_d.prdata[acs_pkg::B_FREE_RUN] = st_q.free_run;
          st_d.prdata[acs_pkg::B_RES10]    = st_q.res10;
          st_d.prdata[acs_pkg::B_LJUST]    = st_q.ljust;
          st_d.prdata[acs_pkg::B_DIFF]     = st_q.diff;
        end
        acs_pkg::OFS_CTRL_B: begin
          st_d.prdata[2:0]                = st_q.samp_sel;
          st_d.prdata[acs_pkg::B_TRUNC]   = st_q.trunc;
        end
        acs_pkg::OFS_CTRL_C:   st_d.prdata[2:0] = st_q.div_sel;
        acs_pkg::OFS_POS_SEL:  st_d.prdata[4:0] = st_q.pos_req;
        acs_pkg::OFS_NEG_SEL:  st_d.prdata[4:0] = st_q.neg_req;
        acs_pkg::OFS_COMMAND:  st_d.prdata[acs_pkg::B_START] = st_q.busy;
        acs_pkg::OFS_EV_CTRL:  st_d.prdata[acs_pkg::B_EV_EN] = st_q.ev_en;
        acs_pkg::OFS_INT_CTRL: st_d.prdata[acs_pkg::B_RDY_IE] = st_q.rdy_ie;
        acs_pkg::OFS_INT_FLAG: st_d.prdata[acs_pkg::B_RDY_FLAG] = st_q.flag;
        acs_pkg::OFS_RESULT:   st_d.prdata[15:0] = st_q.res;
        default:               st_d.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign prdata                = st_q.prdata;
  assign pready                = st_q.pready;
  assign pslverr               = st_q.pslverr;
  assign adc_clk               = st_q.adc_clk;
  assign sample_hold           = st_q.sh;
  assign converting            = st_q.cv;
  assign positive_input_select = st_q.pos_cur;
  assign negative_input_select = st_q.neg_cur;
  assign differential_select   = st_q.diff;
  assign resolution_select     = st_q.res10;
  assign irq                   = st_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_format_two;
    st_q.state == acs_pkg::ST_FORMAT ##1 st_q.state == acs_pkg::ST_FORMAT;
  endsequence

  a_start_next: assert property (trig |=> st_q.busy && st_q.sh) // R14
    else $error("conversion did not begin one cycle after trigger");
  a_start_clears: assert property (done && !st_q.free_run |=>
    !st_q.busy && st_q.flag) // R1
    else $error("start bit not cleared at completion");
  a_flag_polled: assert property (done |=> st_q.flag) // R3
    else $error("result ready flag not set on completion");
  a_irq_gated: assert property (##1 st_q.irq == (st_q.flag && st_q.rdy_ie))
    // R4
    else $error("interrupt request does not follow flag and enable");
  a_event_masked: assert property (event_in && !st_q.ev_prev &&
    !st_q.ev_en && !start_wr && !st_q.busy |=> !st_q.busy) // R5
    else $error("event started a conversion while disabled");
  a_event_start: assert property (ev_rise && st_q.enable && !st_q.busy
    |=> st_q.busy) // R6
    else $error("enabled event edge did not start a conversion");
  a_free_restart: assert property (done && st_q.free_run |=>
    st_q.busy && st_q.state == acs_pkg::ST_SAMPLE && st_q.acc == '0)
    // R7 R8
    else $error("free running restart missing");
  a_channel_held: assert property (st_q.busy && !trig && !done &&
    st_q.state != acs_pkg::ST_IDLE |=> $stable(st_q.pos_cur) &&
    $stable(st_q.neg_cur)) // R2
    else $error("channel changed during conversion");
  a_idle_clock_divider_select: assert property (!st_q.busy |-> !st_q.clock_divider_select_run) // R13
    else $error("prescaler running while idle");
  a_sample_len: assert property (st_q.state == acs_pkg::ST_SAMPLE &&
    half_tick && st_q.hcnt == 5'h03 |=>
    st_q.state == acs_pkg::ST_CONV) // R19
    else $error("sample phase length wrong");
  a_format_len: assert property ($rose(st_q.state == acs_pkg::ST_FORMAT)
    |-> s_format_two ##1 st_q.state != acs_pkg::ST_FORMAT) // R20
    else $error("format phase is not two cycles");
  a_result_first: assert property ($changed(st_q.res) |-> st_q.flag) // R21
    else $error("result changed without result ready");
  a_busy_trigger: assert property (st_q.busy && start_wr && // R22
    st_q.state == acs_pkg::ST_CONV |=> st_q.busy &&
    (st_q.state == acs_pkg::ST_CONV || st_q.state == acs_pkg::ST_FORMAT))
    else $error("start write disturbed running conversion");

endmodule : acs_sequencer

// ===== logic/acs_pkg.sv
package acs_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] OFS_CTRL_A   = 8'h00;
  localparam logic [7:0] OFS_CTRL_B   = 8'h04;
  localparam logic [7:0] OFS_CTRL_C   = 8'h08;
  localparam logic [7:0] OFS_POS_SEL  = 8'h0C;
  localparam logic [7:0] OFS_NEG_SEL  = 8'h10;
  localparam logic [7:0] OFS_COMMAND  = 8'h14;
  localparam logic [7:0] OFS_EV_CTRL  = 8'h18;
  localparam logic [7:0] OFS_INT_CTRL = 8'h1C;
  localparam logic [7:0] OFS_INT_FLAG = 8'h20;
  localparam logic [7:0] OFS_RESULT   = 8'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned B_ENABLE   = 0;
  localparam int unsigned B_FREE_RUN = 1;
  localparam int unsigned B_RES10    = 2;
  localparam int unsigned B_LJUST    = 4;
  localparam int unsigned B_DIFF     = 5;
  localparam int unsigned B_TRUNC    = 3;
  localparam int unsigned B_START    = 0;
  localparam int unsigned B_EV_EN    = 0;
  localparam int unsigned B_RDY_IE   = 0;
  localparam int unsigned B_RDY_FLAG = 0;
  localparam int unsigned SEL_W      = 5;
  localparam int unsigned CNT_SEL_W  = 3;
  localparam int unsigned ACC_W      = 20;
  localparam int unsigned SMP_W      = 12;
  localparam int unsigned RES_W      = 16;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [SEL_W-1:0]     RST_SEL   = 5'h00;
  localparam logic [CNT_SEL_W-1:0] RST_CNT   = 3'h0;
  localparam logic [RES_W-1:0]     RST_RES   = 16'h0000;
  // Converter-clock phases counted in half periods: 2 and 13.5 cycles
  localparam logic [4:0] SH_HALVES   = 5'h04;
  localparam logic [4:0] CONV_HALVES = 5'h1B;
  // Result formatting in peripheral-clock cycles
  localparam logic       FMT_LAST    = 1'b1;
  // Truncation starts above 16 samples (select value 4)
  localparam logic [CNT_SEL_W-1:0] TRUNC_FROM = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONV,
    ST_FORMAT
  } acs_state_t;

  // Whole state of the sequencer
  typedef struct packed {
    acs_state_t             state;
    logic                   busy;
    logic                   enable;
    logic                   free_run;
    logic                   res10;
    logic                   ljust;
    logic                   diff;
    logic                   trunc;
    logic [CNT_SEL_W-1:0]   samp_sel;
    logic [CNT_SEL_W-1:0]   div_sel;
    logic [SEL_W-1:0]       pos_req;
    logic [SEL_W-1:0]       neg_req;
    logic [SEL_W-1:0]       pos_cur;
    logic [SEL_W-1:0]       neg_cur;
    logic                   ev_en;
    logic                   ev_prev;
    logic                   rdy_ie;
    logic                   flag;
    logic                   irq;
    logic [4:0]             hcnt;
    logic                   fcnt;
    logic [7:0]             left;
    logic signed [ACC_W-1:0] acc;
    logic [RES_W-1:0]       res;
    logic                   clock_divider_select_run;
    logic                   adc_clk;
    logic                   sh;
    logic                   cv;
    logic                   pready;
    logic                   pslverr;
    logic [DATA_W-1:0]      prdata;
  } acs_regs_t;

  // Prescaler state
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } acs_clock_divider_select_t;

endpackage : acs_pkg

// ===== logic/acs_prescaler.sv
`timescale 1ns/10ps
module acs_prescaler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            half_tick
);

  acs_pkg::acs_clock_divider_select_t st_q;
  acs_pkg::acs_clock_divider_select_t st_d;
  logic [7:0]          limit;

  // ****************************************************************
  // Half-period divider, held cleared while not running
  // ****************************************************************
  // Period of converter clock is 2^(div_sel+1) peripheral cycles
  always_comb begin
    limit = 8'((8'h01 << div_sel) - 8'h01); // R11
    st_d  = st_q;
    if (!run) begin
      st_d.cnt  = 8'h00; // R13
      st_d.tick = 1'b0;
    end else if (st_q.cnt == limit) begin
      st_d.cnt  = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt  = 8'(st_q.cnt + 8'h01); // R12
      st_d.tick = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign half_tick = st_q.tick;

  a_clock_divider_select_held: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> st_q.cnt == 8'h00 && !st_q.tick) // R13
    else $error("prescaler counts while held");

endmodule : acs_prescaler

// ===== tb/acs_core_model.sv
`timescale 1ns/10ps
// ****
// Converter core model
// ****
module acs_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       converting,
  input  wire logic [4:0] positive_input_select,
  output logic [11:0]     core_data
);
  logic [6:0]  cnt_q;
  logic [11:0] val_q;
  logic        conv_q;
  // Each sample carries its channel, so a late channel switch shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
      val_q <= 12'h000;
      conv_q <= 1'b0;
    end else begin
      conv_q <= converting;
      if (converting && !conv_q) begin
        val_q <= {positive_input_select, cnt_q};
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end
  // Outside conversion the lines show garbage, never the held sample
  assign core_data = conv_q ? val_q : ~val_q;
endmodule : acs_core_model

// ===== tb/acs_sequencer_test.sv
`timescale 1ns/10ps
module acs_sequencer_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        event_in;
  logic [11:0] core_data;
  logic        adc_clk;
  logic        sample_hold;
  logic        converting;
  logic [4:0]  pos_sel;
  logic [4:0]  neg_sel;
  logic        diff_sel;
  logic        res_sel;
  logic        irq;
  logic [31:0] rd;
  logic        rd_err;
  int          err_count;
  int          num_checks;
  int          cycles;
  int          smp;
  int          cfgs [8] = '{'h100, 'h010, 'h020, 'h030, 'h040, 'h203,
                           'h00F, 'h005};

  acs_sequencer acs_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in),
    .core_data(core_data), .adc_clk(adc_clk), .sample_hold(sample_hold),
    .converting(converting), .positive_input_select(pos_sel),
    .negative_input_select(neg_sel), .differential_select(diff_sel),
    .resolution_select(res_sel), .irq(irq));
  acs_core_model acs_core_model_inst (
    .pclk(pclk), .presetn(presetn), .converting(converting),
    .positive_input_select(pos_sel), .core_data(core_data));

  // ****
  // Checking and bus tasks
  // ****
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t register %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t pin %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rd_err = pslverr;
    if (n == 20) begin
      err_count++;
      $display("ERROR %0t no ready from slave", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input int e);
    apb(1'b0, a, 0);
    cmp_reg(rd, e);
  endtask : rd_chk

  // Result from the rules: channel-tagged samples, sum, then format
  function automatic logic [31:0] exp_res(int pos, int c);
    int n;
    int s;
    int sum;
    n = 1 << (c & 7);
    sum = 0;
    for (int k = 0; k < n; k++) begin
      s = (pos << 7) | ((smp + k) & 127);
      if (c[6] && s > 2047) s -= 4096;
      sum += s;
    end
    if (n == 1 && c[4]) sum = sum >>> 2;
    if (n == 1 && c[5]) sum = sum << (c[4] ? 6 : 4);
    if (n > 16 && c[3]) sum = sum >>> ($clog2(n) - 4);
    return {16'h0000, sum[15:0]};
  endfunction : exp_res

  // Settings only while idle, enable written last
  task automatic setup(int c, int pos, int fr);
    int a;
    a = ((c >> 2) & 4) | ((c >> 1) & 48) | (fr << 1);
    apb(1'b1, acs_pkg::OFS_CTRL_A, a);
    apb(1'b1, acs_pkg::OFS_CTRL_B, c & 15);
    apb(1'b1, acs_pkg::OFS_CTRL_C, (c >> 8) & 7);
    apb(1'b1, acs_pkg::OFS_POS_SEL, pos);
    apb(1'b1, acs_pkg::OFS_NEG_SEL, pos ^ 31);
    apb(1'b1, acs_pkg::OFS_CTRL_A, a | 1);
  endtask : setup

  // Poll the flag, check interrupt and result, then clear the flag
  task automatic done(int c, int pos, logic ie);
    int n;
    n = 0;
    do begin
      apb(1'b0, acs_pkg::OFS_INT_FLAG, 0);
      n++;
    end while (rd[0] !== 1'b1 && n < 2000);
    cmp_reg(rd, 1);
    cmp_pin(irq, ie);
    rd_chk(acs_pkg::OFS_RESULT, exp_res(pos, c));
    smp += 1 << (c & 7);
    apb(1'b1, acs_pkg::OFS_INT_FLAG, 1);
  endtask : done

  task automatic run(int c, int pos);
    int n;
    int h;
    setup(c, pos, 0);
    cmp_pin(res_sel, c[4]);
    cmp_pin(diff_sel, c[6]);
    apb(1'b1, acs_pkg::OFS_COMMAND, 1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_hold !== 1'b1 && n < 3);
    cmp_pin(n <= 2, 1);
    rd_chk(acs_pkg::OFS_COMMAND, 1);
    n = 0;
    while (adc_clk !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    h = 0;
    while (adc_clk === 1'b1 && h < 300) begin
      @(posedge pclk);
      h++;
    end
    cmp_reg(h, 1 << ((c >> 8) & 7));
    done(c, pos, 1'b0);
    rd_chk(acs_pkg::OFS_COMMAND, 0);
    cmp_pin(adc_clk, 0);
  endtask : run

  task automatic pulse();
    @(posedge pclk);
    event_in <= 1'b1;
    repeat ($urandom % 3 + 1) @(posedge pclk);
    event_in <= 1'b0;
  endtask : pulse

  // ****
  // Clock, timeout and main sequence
  // ****
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Whole run needs well under this many cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, event_in} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_count = $urandom(96);
    {err_count, num_checks, cycles, smp} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(acs_pkg::OFS_CTRL_A, 0);
    rd_chk(acs_pkg::OFS_RESULT, 0);
    rd_chk(acs_pkg::OFS_INT_FLAG, 0);
    apb(1'b0, 8'h3C, 0);
    cmp_pin(rd_err, 1);
    cmp_reg(rd, 0);
    $display("test reset done");
    foreach (cfgs[i]) run(cfgs[i], $urandom % 32);
    $display("test formats done");
    setup(0, 3, 0);
    apb(1'b1, acs_pkg::OFS_COMMAND, 1);
    apb(1'b1, acs_pkg::OFS_POS_SEL, 9);
    cmp_pin(pos_sel, 3);
    done(0, 3, 1'b0);
    apb(1'b1, acs_pkg::OFS_INT_CTRL, 1);
    apb(1'b1, acs_pkg::OFS_COMMAND, 1);
    // Channel latches at the edge that takes the start; look one edge later
    @(posedge pclk);
    cmp_pin(pos_sel, 9);
    done(0, 9, 1'b1);
    repeat (3) @(posedge pclk);
    cmp_pin(irq, 0);
    apb(1'b1, acs_pkg::OFS_INT_CTRL, 0);
    $display("test channel and interrupt done");
    pulse();
    repeat (4) @(posedge pclk);
    rd_chk(acs_pkg::OFS_COMMAND, 0);
    apb(1'b1, acs_pkg::OFS_EV_CTRL, 1);
    pulse();
    rd_chk(acs_pkg::OFS_COMMAND, 1);
    apb(1'b1, acs_pkg::OFS_COMMAND, 1);
    pulse();
    done(0, 9, 1'b0);
    rd_chk(acs_pkg::OFS_COMMAND, 0);
    repeat (60) @(posedge pclk);
    rd_chk(acs_pkg::OFS_INT_FLAG, 0);
    apb(1'b1, acs_pkg::OFS_EV_CTRL, 0);
    $display("test events done");
    setup(0, 5, 1);
    apb(1'b1, acs_pkg::OFS_COMMAND, 1);
    done(0, 5, 1'b0);
    done(0, 5, 1'b0);
    apb(1'b1, acs_pkg::OFS_CTRL_A, 1);
    done(0, 5, 1'b0);
    repeat (60) @(posedge pclk);
    rd_chk(acs_pkg::OFS_INT_FLAG, 0);
    rd_chk(acs_pkg::OFS_COMMAND, 0);
    $display("test free running done");
    end_sim();
  end
endmodule : acs_sequencer_test
